// ---- hdl/idsr_addr_step.sv ----
// Next streaming address from the freeze and direction bits
`timescale 1ns/1ps
module idsr_addr_step #(
  parameter int AW = 15
) (
  input logic [AW-1:0] addr,
  input logic freeze,
  input logic ascend,
  output logic [AW-1:0] nextAddr
);
  always_comb begin
    if (freeze) begin
      nextAddr = addr; // [RULE4]
    end else if (ascend) begin
      nextAddr = addr + AW'(1); // [RULE3] [RULE13]
    end else begin
      nextAddr = addr - AW'(1); // [RULE3] [RULE13]
    end
  end
endmodule

// ---- hdl/idsr_map.svh ----
// Register offsets, field positions, reset values and counts for the id and SYSREF control bank
`ifndef IDSR_MAP_SVH
`define IDSR_MAP_SVH

`define IDSR_ADDR_W 15
`define IDSR_ADDR_CONFIG_A 15'h0000
`define IDSR_ADDR_FAMILY_LO 15'h0004
`define IDSR_ADDR_FAMILY_HI 15'h0005
`define IDSR_ADDR_MAKER_LO 15'h000C
`define IDSR_ADDR_MAKER_HI 15'h000D
`define IDSR_ADDR_USER_CFG 15'h0010
`define IDSR_ADDR_CTRL0 15'h0029
`define IDSR_ADDR_CTRL1 15'h002A

`define IDSR_SOFT_RESET_BIT 7
`define IDSR_ASCEND_BIT 5
`define IDSR_SDO_ACTIVE_BIT 4
`define IDSR_FREEZE_BIT 0
`define IDSR_PROC_EN_BIT 6
`define IDSR_RECV_EN_BIT 5
`define IDSR_ZOOM_BIT 4
`define IDSR_SEL_HI 3
`define IDSR_SEL_LO 0

`define IDSR_CONFIG_A_RESET 8'h30
`define IDSR_USER_CFG_RESET 8'h00
`define IDSR_CTRL0_RESET 8'h00
`define IDSR_CTRL1_RESET 8'h00

`define IDSR_INSTR_LAST 4'hF
`define IDSR_BYTE_LAST 4'h7

`endif

// ---- hdl/idsr_pkg.sv ----
// Types shared by the id and SYSREF control bank
package idsr_pkg;

  typedef enum logic [1:0] {
    IDSR_IDLE,
    IDSR_INSTR,
    IDSR_DATA
  } idsr_phase_e;

  typedef struct packed {
    logic meta;
    logic stable;
  } idsr_sync_s;

  typedef struct packed {
    idsr_phase_e phase;
    logic sclkPrev;
    logic [3:0] bitCnt;
    logic [14:0] instr;
    logic isRead;
    logic [14:0] addr;
    logic [6:0] rxByte;
    logic [7:0] txShift;
    logic sdo;
    logic sdoEn;
    logic [7:0] configA;
    logic [7:0] userCfg;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
  } idsr_state_s;

endpackage

// ---- hdl/idsr_regs.sv ----
// Serial port register slave: identification and SYSREF capture control
`timescale 1ns/1ps
`include "idsr_map.svh"
// Summary of operation
// RULE1 - Family id register at 0x4 is 16-bit read-only with fixed code
// RULE2 - Maker id register at 0xC is 16-bit read-only with fixed code
// RULE3 - Freeze bit clear (reset) lets streaming step address per direction bit
// RULE4 - Freeze bit set holds the address for every streamed byte
// RULE5 - Control bit 5 enables SYSREF receiver; off after reset
// RULE6 - Control bit 6 enables SYSREF processor; off after reset
// RULE7 - Host enables receiver before or with processor
// RULE8 - Control bit 4 selects finer SYSREF windowing delay steps
// RULE9 - Bits 3:0 choose SYSREF capture delay, set from capture position
// RULE10 - Host keeps delay choice zero when automatic calibration is used
// RULE11 - Capture control register at 0x29 resets to 0x00
// RULE12 - User config register at 0x10 resets to 0x00
// RULE13 - Direction bit one (reset) increments, zero decrements streaming address
module idsr_regs #(
  parameter logic [15:0] FAMILY_CODE = 16'h5A3C, // Arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h1E2D // Arbitrary value
) (
  input logic mclk,
  input logic reset_n,
  input logic sclkPin,
  input logic chipSelectN,
  input logic sdiPin,
  output logic sdoPin,
  output logic sdoEnable,
  output logic sysrefReceiverEnable,
  output logic sysrefProcessorEnable,
  output logic sysrefFineWindow,
  output logic [3:0] sysrefDelayChoice,
  output logic [7:0] clockControlSecond
);
  localparam idsr_pkg::idsr_state_s RESET_STATE = '{
    phase: idsr_pkg::IDSR_IDLE,
    sclkPrev: 1'b0,
    bitCnt: 4'h0,
    instr: 15'h0000,
    isRead: 1'b0,
    addr: 15'h0000,
    rxByte: 7'h00,
    txShift: 8'h00,
    sdo: 1'b0,
    sdoEn: 1'b0,
    configA: `IDSR_CONFIG_A_RESET,
    userCfg: `IDSR_USER_CFG_RESET,
    ctrl0: `IDSR_CTRL0_RESET,
    ctrl1: `IDSR_CTRL1_RESET
  };

  idsr_pkg::idsr_state_s state_q, state_d;

  logic sclkSync;
  logic chipSelectSyncN;
  logic sdiSync;
  logic selected;
  logic sclkRise;
  logic sclkFall;
  logic instrDone;
  logic byteDone;
  logic wrByte;
  logic loadRead;
  logic [15:0] instrFull;
  logic [7:0] rxFull;
  logic [14:0] stepAddr;
  logic [14:0] loadAddr;

  // Pins are asynchronous to mclk; equal latency keeps data aligned with clock
  idsr_sync2 #(.RESET_VAL(1'b0)) uSyncSclk (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(sclkPin),
    .dout(sclkSync)
  );

  idsr_sync2 #(.RESET_VAL(1'b1)) uSyncCs (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(chipSelectN),
    .dout(chipSelectSyncN)
  );

  idsr_sync2 #(.RESET_VAL(1'b0)) uSyncSdi (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(sdiPin),
    .dout(sdiSync)
  );

  idsr_addr_step #(.AW(`IDSR_ADDR_W)) uStep (
    .addr(state_q.addr),
    .freeze(state_q.userCfg[`IDSR_FREEZE_BIT]),
    .ascend(state_q.configA[`IDSR_ASCEND_BIT]),
    .nextAddr(stepAddr)
  );

  assign selected = ~chipSelectSyncN;
  assign sclkRise = sclkSync & ~state_q.sclkPrev;
  assign sclkFall = ~sclkSync & state_q.sclkPrev;
  assign instrFull = {state_q.instr, sdiSync};
  assign rxFull = {state_q.rxByte, sdiSync};
  assign instrDone = selected && (state_q.phase == idsr_pkg::IDSR_INSTR) && sclkRise
    && (state_q.bitCnt == `IDSR_INSTR_LAST);
  assign byteDone = selected && (state_q.phase == idsr_pkg::IDSR_DATA) && sclkRise
    && (state_q.bitCnt == `IDSR_BYTE_LAST);
  assign wrByte = byteDone && !state_q.isRead;
  assign loadAddr = instrDone ? instrFull[14:0] : stepAddr;
  assign loadRead = instrDone ? instrFull[15] : (byteDone && state_q.isRead);

  // Unmapped addresses read as zero
  function automatic logic [7:0] readByteOf(
    input logic [14:0] a,
    input idsr_pkg::idsr_state_s s
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `IDSR_ADDR_CONFIG_A: begin
        r = s.configA;
        r[`IDSR_SOFT_RESET_BIT] = 1'b0;
        r[`IDSR_SDO_ACTIVE_BIT] = 1'b1;
      end
      `IDSR_ADDR_FAMILY_LO: r = FAMILY_CODE[7:0]; // [RULE1]
      `IDSR_ADDR_FAMILY_HI: r = FAMILY_CODE[15:8]; // [RULE1]
      `IDSR_ADDR_MAKER_LO: r = MAKER_CODE[7:0]; // [RULE2]
      `IDSR_ADDR_MAKER_HI: r = MAKER_CODE[15:8]; // [RULE2]
      `IDSR_ADDR_USER_CFG: r = s.userCfg;
      `IDSR_ADDR_CTRL0: r = s.ctrl0;
      `IDSR_ADDR_CTRL1: r = s.ctrl1;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.sclkPrev = sclkSync;
    if (!selected) begin
      state_d.phase = idsr_pkg::IDSR_IDLE;
      state_d.bitCnt = 4'h0;
      state_d.sdoEn = 1'b0;
      state_d.sdo = 1'b0;
    end else begin
      case (state_q.phase)
        idsr_pkg::IDSR_IDLE: begin
          // Edges in the select cycle are not taken; host needs setup time
          state_d.phase = idsr_pkg::IDSR_INSTR;
          state_d.bitCnt = 4'h0;
        end
        idsr_pkg::IDSR_INSTR: begin
          if (sclkRise) begin
            state_d.instr = instrFull[14:0];
            state_d.bitCnt = state_q.bitCnt + 4'h1;
            if (instrDone) begin
              state_d.phase = idsr_pkg::IDSR_DATA;
              state_d.bitCnt = 4'h0;
              state_d.isRead = instrFull[15];
              state_d.addr = instrFull[14:0];
              state_d.sdoEn = instrFull[15];
            end
          end
        end
        idsr_pkg::IDSR_DATA: begin
          if (sclkRise) begin
            state_d.rxByte = rxFull[6:0];
            state_d.bitCnt = state_q.bitCnt + 4'h1;
            if (byteDone) begin
              state_d.bitCnt = 4'h0;
              state_d.addr = stepAddr; // [RULE3] [RULE4] [RULE13]
            end
          end else if (sclkFall && state_q.isRead) begin
            // Shift on the falling edge so the host samples on the rising one
            state_d.sdo = state_q.txShift[7];
            state_d.txShift = {state_q.txShift[6:0], 1'b0};
          end
        end
        default: begin
          state_d.phase = idsr_pkg::IDSR_IDLE;
        end
      endcase
    end
    if (loadRead) begin
      state_d.txShift = readByteOf(loadAddr, state_q);
    end
    if (wrByte) begin
      case (state_q.addr)
        `IDSR_ADDR_CONFIG_A: begin
          if (rxFull[`IDSR_SOFT_RESET_BIT]) begin
            // Self-clearing: bank returns to reset values, frame carries on
            state_d.configA = `IDSR_CONFIG_A_RESET;
            state_d.userCfg = `IDSR_USER_CFG_RESET;
            state_d.ctrl0 = `IDSR_CTRL0_RESET;
            state_d.ctrl1 = `IDSR_CTRL1_RESET;
          end else begin
            state_d.configA = rxFull;
          end
        end
        `IDSR_ADDR_USER_CFG: state_d.userCfg = rxFull; // [RULE4]
        `IDSR_ADDR_CTRL0: state_d.ctrl0 = rxFull; // [RULE5] [RULE6] [RULE8] [RULE9]
        `IDSR_ADDR_CTRL1: state_d.ctrl1 = rxFull;
        default: state_d.ctrl1 = state_d.ctrl1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= RESET_STATE; // [RULE11] [RULE12]
    end else begin
      state_q <= state_d;
    end
  end

  assign sdoPin = state_q.sdo;
  assign sdoEnable = state_q.sdoEn;
  // Ordering of receiver and processor enables is left to the host
  assign sysrefReceiverEnable = state_q.ctrl0[`IDSR_RECV_EN_BIT]; // [RULE5] [RULE7]
  assign sysrefProcessorEnable = state_q.ctrl0[`IDSR_PROC_EN_BIT]; // [RULE6]
  assign sysrefFineWindow = state_q.ctrl0[`IDSR_ZOOM_BIT]; // [RULE8]
  assign sysrefDelayChoice = state_q.ctrl0[`IDSR_SEL_HI:`IDSR_SEL_LO]; // [RULE9] [RULE10]
  assign clockControlSecond = state_q.ctrl1;

  family_id_read_a: assert property ( // [RULE1]
    @(posedge mclk) disable iff (!reset_n)
    (loadRead && loadAddr == `IDSR_ADDR_FAMILY_LO)
    |=> (state_q.txShift == FAMILY_CODE[7:0])
  ) else $error("family id low byte not loaded");

  maker_id_read_a: assert property ( // [RULE2]
    @(posedge mclk) disable iff (!reset_n)
    (loadRead && loadAddr == `IDSR_ADDR_MAKER_HI)
    |=> (state_q.txShift == MAKER_CODE[15:8])
  ) else $error("maker id high byte not loaded");

  addr_ascend_a: assert property ( // [RULE3]
    @(posedge mclk) disable iff (!reset_n)
    (byteDone && !state_q.userCfg[`IDSR_FREEZE_BIT] && state_q.configA[`IDSR_ASCEND_BIT])
    |=> (state_q.addr == $past(state_q.addr) + 15'h0001)
  ) else $error("streaming address did not increment");

  addr_descend_a: assert property ( // [RULE13]
    @(posedge mclk) disable iff (!reset_n)
    (byteDone && !state_q.userCfg[`IDSR_FREEZE_BIT] && !state_q.configA[`IDSR_ASCEND_BIT])
    |=> (state_q.addr == $past(state_q.addr) - 15'h0001)
  ) else $error("streaming address did not decrement");

  addr_freeze_a: assert property ( // [RULE4]
    @(posedge mclk) disable iff (!reset_n)
    (byteDone && state_q.userCfg[`IDSR_FREEZE_BIT])
    |=> $stable(state_q.addr)
  ) else $error("frozen address moved");

  recv_enable_a: assert property ( // [RULE5]
    @(posedge mclk) disable iff (!reset_n)
    (wrByte && state_q.addr == `IDSR_ADDR_CTRL0)
    |=> (sysrefReceiverEnable == $past(rxFull[5]))
  ) else $error("receiver enable not taken from write");

  proc_enable_a: assert property ( // [RULE6]
    @(posedge mclk) disable iff (!reset_n)
    (wrByte && state_q.addr == `IDSR_ADDR_CTRL0)
    |=> (sysrefProcessorEnable == $past(rxFull[6]))
  ) else $error("processor enable not taken from write");

  window_delay_a: assert property ( // [RULE8] [RULE9]
    @(posedge mclk) disable iff (!reset_n)
    (wrByte && state_q.addr == `IDSR_ADDR_CTRL0)
    |=> (sysrefFineWindow == $past(rxFull[4]) && sysrefDelayChoice == $past(rxFull[3:0]))
  ) else $error("zoom or delay choice not taken from write");

  ctrl_reset_a: assert property ( // [RULE11]
    @(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> (state_q.ctrl0 == 8'h00 && !sysrefReceiverEnable
      && !sysrefProcessorEnable && sysrefDelayChoice == 4'h0)
  ) else $error("capture control not zero after reset");

  user_reset_a: assert property ( // [RULE12]
    @(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> (state_q.userCfg == 8'h00 && state_q.configA == 8'h30)
  ) else $error("user config not at reset value");
endmodule

// ---- hdl/idsr_sync2.sv ----
// Two-stage synchroniser for one serial port pin
`timescale 1ns/1ps
module idsr_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input logic mclk,
  input logic reset_n,
  input logic din,
  output logic dout
);
  idsr_pkg::idsr_sync_s sync_q, sync_d;

  always_comb begin
    sync_d = sync_q;
    sync_d.meta = din;
    sync_d.stable = sync_q.meta;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync_q <= '{meta: RESET_VAL, stable: RESET_VAL};
    end else begin
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q.stable;
endmodule

// ---- test/id_and_sysref_control_regs_tb.sv ----
// Self-checking bench for the id and SYSREF control register bank
`timescale 1ns/1ps
module id_and_sysref_control_regs_tb;
  localparam logic [15:0] FAM = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] MAK = 16'h3C96; // Arbitrary value
  logic mclk;
  logic reset_n;
  logic sclkPin;
  logic chipSelectN;
  logic sdiPin;
  logic sdoPin;
  logic sdoEnable;
  logic sysrefReceiverEnable;
  logic sysrefProcessorEnable;
  logic sysrefFineWindow;
  logic [3:0] sysrefDelayChoice;
  logic [7:0] clockControlSecond;
  logic [31:0] ctrlPins;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  assign ctrlPins = {25'h0, sysrefProcessorEnable, sysrefReceiverEnable, sysrefFineWindow,
      sysrefDelayChoice};

  idsr_regs #(.FAMILY_CODE(FAM), .MAKER_CODE(MAK)) uut (
    .mclk(mclk),
    .reset_n(reset_n),
    .sclkPin(sclkPin),
    .chipSelectN(chipSelectN),
    .sdiPin(sdiPin),
    .sdoPin(sdoPin),
    .sdoEnable(sdoEnable),
    .sysrefReceiverEnable(sysrefReceiverEnable),
    .sysrefProcessorEnable(sysrefProcessorEnable),
    .sysrefFineWindow(sysrefFineWindow),
    .sysrefDelayChoice(sysrefDelayChoice),
    .clockControlSecond(clockControlSecond)
  );

  idsr_host_model host (
    .mclk(mclk),
    .sclkPin(sclkPin),
    .chipSelectN(chipSelectN),
    .sdiPin(sdiPin),
    .sdoPin(sdoPin),
    .sdoEnable(sdoEnable)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard well above the roughly 15k cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.frame({1'b0, a}, n, d, r, e);
  endtask

  task automatic rd(input logic [14:0] a, input int n, output logic [31:0] r);
    logic e;
    host.frame({1'b1, a}, n, 32'h0000_0000, r, e);
  endtask

  task automatic testReset();
    logic [31:0] r;
    checkVal(ctrlPins, 32'h0, "control pins after reset");
    rd(15'h0029, 1, r);
    checkVal(r, 32'h0, "capture control reset");
    rd(15'h0010, 1, r);
    checkVal(r, 32'h0, "user config reset");
  endtask

  task automatic testIds();
    logic [31:0] r;
    logic e;
    host.frame({1'b1, 15'h0004}, 2, 32'h0000_0000, r, e);
    checkVal(r, {16'h0, FAM}, "family id");
    checkVal({31'h0, e}, 32'h1, "read drive enable");
    rd(15'h000C, 2, r);
    checkVal(r, {16'h0, MAK}, "maker id");
    // Writes must not disturb read-only codes, nor turn the data driver on
    host.frame({1'b0, 15'h0004}, 2, 32'h0000_FFFF, r, e);
    checkVal({31'h0, e}, 32'h0, "write drive enable");
    wr(15'h000C, 2, 32'h0000_0000);
    rd(15'h0004, 2, r);
    checkVal(r, {16'h0, FAM}, "family id after write");
    rd(15'h000C, 2, r);
    checkVal(r, {16'h0, MAK}, "maker id after write");
  endtask

  task automatic testCtrl();
    logic [31:0] r;
    logic [7:0] d;
    // Receiver goes on first, processor after
    wr(15'h0029, 1, 32'h20);
    checkVal(ctrlPins, 32'h20, "receiver enable");
    wr(15'h0029, 1, 32'h60);
    checkVal(ctrlPins, 32'h60, "processor enable");
    for (int v = 0; v < 16; v++) begin
      d = {3'h3, v[0], v[3:0]};
      wr(15'h0029, 1, {24'h0, d});
      checkVal(ctrlPins, {24'h0, d}, "zoom and delay pins");
      rd(15'h0029, 1, r);
      checkVal(r, {24'h0, d}, "capture control readback");
    end
    // Delay choice back to zero ahead of automatic calibration
    wr(15'h0029, 1, 32'h60);
    checkVal(ctrlPins, 32'h60, "delay cleared");
  endtask

  task automatic testStream();
    logic [31:0] r;
    wr(15'h0029, 2, 32'h5A25);
    checkVal(ctrlPins, 32'h25, "ascending first byte");
    checkVal({24'h0, clockControlSecond}, 32'h5A, "ascending second byte");
    wr(15'h0000, 1, 32'h00);
    rd(15'h000D, 2, r);
    checkVal(r, {16'h0, MAK[7:0], MAK[15:8]}, "descending read");
    wr(15'h002A, 2, 32'h0F11);
    checkVal({24'h0, clockControlSecond}, 32'h11, "descending first byte");
    checkVal(ctrlPins, 32'h0F, "descending second byte");
    wr(15'h0000, 1, 32'h30);
  endtask

  task automatic testFreeze();
    logic [31:0] r;
    wr(15'h0010, 1, 32'h01);
    wr(15'h0029, 2, 32'h0325);
    checkVal(ctrlPins, 32'h03, "frozen write last byte");
    checkVal({24'h0, clockControlSecond}, 32'h11, "neighbour untouched");
    rd(15'h0004, 2, r);
    checkVal(r, {16'h0, FAM[7:0], FAM[7:0]}, "frozen read");
    wr(15'h0010, 1, 32'h00);
    rd(15'h0004, 2, r);
    checkVal(r, {16'h0, FAM}, "freeze released");
  endtask

  task automatic testSoftReset();
    logic [31:0] r;
    wr(15'h0010, 1, 32'h01);
    // Self-clearing reset bit returns the bank to its reset values
    wr(15'h0000, 1, 32'h80);
    checkVal(ctrlPins, 32'h0, "control pins after soft reset");
    checkVal({24'h0, clockControlSecond}, 32'h0, "second control after soft reset");
    rd(15'h0010, 1, r);
    checkVal(r, 32'h0, "user config after soft reset");
    rd(15'h0000, 1, r);
    checkVal(r, 32'h30, "ascending default after soft reset");
  endtask

  initial begin
    reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    testReset();
    testIds();
    testCtrl();
    testStream();
    testFreeze();
    testSoftReset();
    results();
  end
endmodule

// ---- test/idsr_host_model.sv ----
// Host serial port controller model driving the register bank pins
`timescale 1ns/1ps
module idsr_host_model (
  input wire logic mclk,
  output logic sclkPin,
  output logic chipSelectN,
  output logic sdiPin,
  input wire logic sdoPin,
  input wire logic sdoEnable
);
  initial begin
    sclkPin = 1'b0;
    chipSelectN = 1'b1;
    sdiPin = 1'b0;
  end

  // Each sclk phase is 5 mclk, above the 2 mclk the synchronisers need
  task automatic halfBit();
    repeat (5) @(negedge mclk);
  endtask

  // Instruction word then nBytes whole bytes; first byte travels in bits 7:0
  task automatic frame(input logic [15:0] instr, input int nBytes, input logic [31:0] wdat,
      output logic [31:0] rdat, output logic enAll);
    int i;
    int k;
    rdat = 32'h0000_0000;
    enAll = 1'b1;
    @(negedge mclk);
    chipSelectN = 1'b0;
    halfBit();
    for (i = 0; i < 16 + 8 * nBytes; i++) begin
      k = 8 * ((i - 16) / 8) + 7 - (i % 8);
      sdiPin = (i < 16) ? instr[15 - i] : wdat[k];
      halfBit();
      // Sample late in the low phase, after the device has shifted
      if (i >= 16) begin
        rdat[k] = sdoPin;
        enAll = enAll & sdoEnable;
      end
      sclkPin = 1'b1;
      halfBit();
      sclkPin = 1'b0;
    end
    halfBit();
    chipSelectN = 1'b1;
    // Released line toggles so a stale value is never mistaken for data
    sdiPin = ~sdiPin;
    halfBit();
  endtask
endmodule
